//--- dv/fac_cpu_model.sv
/*
 CPU side model: array and register transfers.
 Assumes answers come one cycle after the request edge.
*/
`timescale 1ns/1ps
module fac_cpu_model (
   // Clock
   input wire logic ref_clk,
   // Array bus
   output fac_pkg::fac_abus_t abus,
   output logic [31:0] abus_wdata,
   input wire logic [31:0] abus_rdata,
   input wire logic abus_ready,
   input wire logic abus_err,
   // Peripheral bus
   output fac_pkg::fac_pbus_t pbus,
   input wire logic [15:0] pbus_rdata,
   input wire logic pbus_ready,
   input wire logic pbus_err
);
   // Buses idle at time zero
   initial
   begin
      abus = '0;
      abus_wdata = '0;
      pbus = '0;
   end
   // One array transfer; released lines show the inverse
   task automatic arr(input logic wr, input logic sup, input logic [16:0] a, output logic [31:0] rd,
                      output logic [1:0] rsp);
      @(posedge ref_clk);
      abus <= '{sel: 1'b1, wr: wr, sup: sup, addr: a};
      @(posedge ref_clk);
      abus <= '{sel: 1'b0, wr: ~wr, sup: ~sup, addr: ~a};
      @(negedge ref_clk);
      rd = abus_rdata;
      rsp = {abus_err, abus_ready};
   endtask
   // One register transfer
   task automatic regs(input logic wr, input logic sup, input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] rd, output logic [1:0] rsp);
      @(posedge ref_clk);
      pbus <= '{sel: 1'b1, wr: wr, sup: sup, addr: a, wdata: wd};
      @(posedge ref_clk);
      pbus <= '{sel: 1'b0, wr: ~wr, sup: ~sup, addr: ~a, wdata: ~wd};
      @(negedge ref_clk);
      rd = pbus_rdata;
      rsp = {pbus_err, pbus_ready};
   endtask
endmodule // fac_cpu_model

//--- dv/fac_ctrl_sva.sv
/*
 Port checker of the flash array controller.
 Assumes a bind to fac_ctrl and one clock domain.
*/
`timescale 1ns/1ps
module fac_ctrl_sva #(
   parameter int PROG_CYCLES = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Requests
   input wire fac_pkg::fac_abus_t abus,
   input wire fac_pkg::fac_pbus_t pbus,
   input wire fac_pkg::fac_dbg_t dbg,
   // Answers
   input wire logic [31:0] abus_rdata,
   input wire logic abus_ready,
   input wire logic abus_err,
   input wire logic pbus_ready,
   input wire logic pbus_err,
   input wire logic dbg_ready,
   input wire fac_pkg::fac_mode_t mode,
   input wire logic standby
);
   logic busy; // Program or erase under way
   logic [15:0] hv_run; // Cycles spent in program mode
   logic [15:0] next_hv_run;
   assign busy = mode == fac_pkg::FAC_PROGRAM || mode == fac_pkg::FAC_ERASE;
   // Length of the current program pulse
   always_comb
   begin
      next_hv_run = (mode == fac_pkg::FAC_PROGRAM) ? hv_run + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         hv_run <= 16'h0000;
      else
         hv_run <= next_hv_run;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Supervisor program command with no program, erase or debug load under way
   sequence s_prog_cmd;
      pbus.sel && pbus.wr && pbus.sup && pbus.addr == fac_pkg::REG_CMD && pbus.wdata == 16'h0001 && !busy && !dbg.valid;
   endsequence
   // Program mode shows one cycle later
   sequence s_prog_on;
      ##1 mode == fac_pkg::FAC_PROGRAM;
   endsequence
   prog_entry_a: assert property (s_prog_cmd |-> s_prog_on)
      else $error("program mode not entered");
   reg_user_a: assert property (pbus.sel && !pbus.sup |=> pbus_err && !pbus_ready)
      else $error("user register access not refused");
   user_no_hv_a: assert property (pbus.sel && !pbus.sup && !busy && !dbg.valid |=> !busy)
      else $error("user access started program or erase");
   arr_user_a: assert property (abus.sel && abus.wr && !abus.sup |=> abus_err && !abus_ready)
      else $error("user array write not refused");
   read_one_a: assert property (abus.sel && !abus.wr && !busy && !dbg.valid |=> abus_ready && mode == fac_pkg::FAC_READ)
      else $error("array read not answered next cycle");
   busy_read_a: assert property (busy && $past(busy) |-> abus_rdata == 32'h00000000)
      else $error("array data shown while busy");
   idle_standby_a: assert property (standby == (mode == fac_pkg::FAC_IDLE))
      else $error("standby disagrees with idle mode");
   hv_bound_a: assert property (hv_run <= 16'(PROG_CYCLES + 2))
      else $error("program pulse too long");
   dbg_gate_a: assert property (dbg_ready == !busy)
      else $error("debug ready wrong");
endmodule // fac_ctrl_sva

bind fac_ctrl fac_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) i_fac_ctrl_sva (.ref_clk(ref_clk), .reset_n(reset_n),
   .abus(abus), .pbus(pbus), .dbg(dbg), .abus_rdata(abus_rdata), .abus_ready(abus_ready), .abus_err(abus_err),
   .pbus_ready(pbus_ready), .pbus_err(pbus_err), .dbg_ready(dbg_ready), .mode(mode), .standby(standby));

//--- dv/flash_array_controller_tb_top.sv
/*
 Testbench: reads, program, erase, debug load and refusals.
 Assumes the CPU model and the bound checker.
*/
`timescale 1ns/1ps
module flash_array_controller_tb_top;
   logic ref_clk;
   logic reset_n;
   fac_pkg::fac_abus_t abus;
   logic [31:0] abus_wdata;
   logic [31:0] abus_rdata;
   logic abus_ready;
   logic abus_err;
   fac_pkg::fac_pbus_t pbus;
   logic [15:0] pbus_rdata;
   logic pbus_ready;
   logic pbus_err;
   fac_pkg::fac_dbg_t dbg; // Debug load word
   logic dbg_ready;
   fac_pkg::fac_mode_t mode;
   logic standby;
   int err_total;
   int total_checks;
   // Controller with short pulses
   fac_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(2)) i_fac_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
      .abus(abus), .abus_wdata(abus_wdata), .abus_rdata(abus_rdata), .abus_ready(abus_ready),
      .abus_err(abus_err), .pbus(pbus), .pbus_rdata(pbus_rdata), .pbus_ready(pbus_ready),
      .pbus_err(pbus_err), .dbg(dbg), .dbg_ready(dbg_ready), .mode(mode), .standby(standby));
   // CPU on the system bus
   fac_cpu_model i_fac_cpu_model (.ref_clk(ref_clk), .abus(abus), .abus_wdata(abus_wdata),
      .abus_rdata(abus_rdata), .abus_ready(abus_ready), .abus_err(abus_err), .pbus(pbus),
      .pbus_rdata(pbus_rdata), .pbus_ready(pbus_ready), .pbus_err(pbus_err));
   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Value compare
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Verdict and end of run
   task automatic results();
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Supervisor word read
   task automatic aread(input logic [14:0] w, input logic [31:0] exp);
      logic [31:0] rd;
      logic [1:0] rsp;
      i_fac_cpu_model.arr(1'b0, 1'b1, {w, 2'b00}, rd, rsp);
      chk("array word", exp, rd);
   endtask
   // Register transfer with expected answer
   task automatic preg(input logic wr, input logic sup, input logic [7:0] a, input logic [15:0] d,
                       input logic [1:0] exp, output logic [15:0] rd);
      logic [1:0] rsp;
      i_fac_cpu_model.regs(wr, sup, a, d, rd, rsp);
      chk("register answer", {30'h0, exp}, {30'h0, rsp});
   endtask
   // Address and data for a command
   task automatic set_word(input logic [14:0] w, input logic [31:0] d);
      logic [15:0] rd;
      preg(1'b1, 1'b1, fac_pkg::REG_ADDR, {1'b0, w}, 2'b01, rd);
      preg(1'b1, 1'b1, fac_pkg::REG_DATA_LO, d[15:0], 2'b01, rd);
      preg(1'b1, 1'b1, fac_pkg::REG_DATA_HI, d[31:16], 2'b01, rd);
   endtask
   // Bounded wait for idle
   task automatic wait_idle();
      int n;
      n = 0;
      while (mode !== fac_pkg::FAC_IDLE && n < 70000)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk("mode", fac_pkg::FAC_IDLE, mode);
   endtask
   // Idle after reset, option word reads erased
   task automatic t_idle();
      logic [31:0] rd;
      logic [1:0] rsp;
      chk("standby", 1, standby);
      i_fac_cpu_model.arr(1'b0, 1'b1, fac_pkg::OPT_BYTE_ADDR, rd, rsp);
      chk("option word", fac_pkg::ERASED_WORD, rd);
      chk("read answer", 1, rsp);
      chk("mode", fac_pkg::FAC_READ, mode);
      aread(15'h7FFF, 32'hFFFFFFFF);
   endtask
   // Program an erased word, read while busy
   task automatic t_prog();
      logic [15:0] rd;
      set_word(15'h00FF, 32'h12340F0F);
      preg(1'b1, 1'b1, fac_pkg::REG_CMD, 16'h0001, 2'b01, rd);
      chk("mode", fac_pkg::FAC_PROGRAM, mode);
      aread(15'h00FF, 32'h00000000);
      wait_idle();
      aread(15'h00FF, 32'h12340F0F);
   endtask
   // Debug load of the first word of page one
   task automatic t_dbg();
      @(posedge ref_clk);
      dbg <= '{valid: 1'b1, cmd: fac_pkg::CMD_PROG, addr: 15'h0100, data: 32'hA5A50F0F};
      @(posedge ref_clk);
      dbg <= '{valid: 1'b0, cmd: 2'h0, addr: 15'h7EFF, data: 32'h5A5AF0F0};
      @(negedge ref_clk);
      chk("debug ready", 0, dbg_ready);
      wait_idle();
      aread(15'h0100, 32'hA5A50F0F);
   endtask
   // User accesses refused and flag the error, array and mode unchanged
   task automatic t_user();
      logic [15:0] rd;
      logic [31:0] rw;
      logic [1:0] rsp;
      preg(1'b1, 1'b0, fac_pkg::REG_CMD, 16'h0002, 2'b10, rd);
      chk("mode", fac_pkg::FAC_IDLE, mode);
      i_fac_cpu_model.arr(1'b1, 1'b0, {15'h00FF, 2'b00}, rw, rsp);
      chk("write answer", 2, rsp);
      aread(15'h00FF, 32'h12340F0F);
      preg(1'b0, 1'b1, fac_pkg::REG_STATUS, 16'h0000, 2'b01, rd);
      chk("error flag", 1, rd[3]);
      preg(1'b1, 1'b1, fac_pkg::REG_STATUS, 16'h0008, 2'b01, rd);
      preg(1'b0, 1'b1, fac_pkg::REG_STATUS, 16'h0000, 2'b01, rd);
      chk("error flag", 0, rd[3]);
   endtask
   // Page erase at the page edge, then mass erase
   task automatic t_erase();
      logic [15:0] rd;
      set_word(15'h00FF, 32'h00000000);
      preg(1'b1, 1'b1, fac_pkg::REG_CMD, 16'h0002, 2'b01, rd);
      chk("mode", fac_pkg::FAC_ERASE, mode);
      wait_idle();
      aread(15'h00FF, fac_pkg::ERASED_WORD);
      aread(15'h0100, 32'hA5A50F0F);
      preg(1'b1, 1'b1, fac_pkg::REG_CMD, 16'h0003, 2'b01, rd);
      wait_idle();
      aread(15'h0100, fac_pkg::ERASED_WORD);
   endtask
   // Main sequence
   initial
   begin
      err_total = 0;
      total_checks = 0;
      reset_n = 1'b0;
      dbg = '0;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      t_idle();
      t_prog();
      t_dbg();
      t_user();
      t_erase();
      results();
   end
   // Watchdog
   initial
   begin
      #(80000 * 25);
      err_total++;
      results();
   end
endmodule // flash_array_controller_tb_top

//--- include/fac_pkg.sv
/*
 Package of the flash array controller: array geometry, peripheral register
 offsets, controller command codes, timing counts and the packed structs that
 carry the array bus, the peripheral bus and the debug load port.
 Assumes a single 40 MHz clock and that every user of it names items as
 fac_pkg::name.
*/
package fac_pkg;

   // Array geometry
   localparam int ADDR_W = 15;                       // Word address width
   localparam int WORDS = 32768;                     // Array depth in words
   localparam int PAGE_W = 8;                        // Words per page, log2
   localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
   localparam logic [16:0] OPT_BYTE_ADDR = 17'h1FFFC; // Start of option bytes

   // Peripheral register offsets (16-bit bus, byte addresses)
   localparam logic [7:0] REG_CMD = 8'h00;     // Command, write starts action
   localparam logic [7:0] REG_ADDR = 8'h02;    // Target word address
   localparam logic [7:0] REG_DATA_LO = 8'h04; // Program data low half
   localparam logic [7:0] REG_DATA_HI = 8'h06; // Program data high half
   localparam logic [7:0] REG_STATUS = 8'h08;  // Mode and busy status

   // Command codes
   localparam logic [1:0] CMD_PROG = 2'h1;
   localparam logic [1:0] CMD_PAGE = 2'h2;
   localparam logic [1:0] CMD_MASS = 2'h3;

   // Status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_MODE_LSB = 1;
   localparam int ST_ERR = 3;

   // High-voltage pulse lengths and their cycle counts at 40 MHz
   localparam int CLK_KHZ = 40000;
   localparam int PROG_US = 40;                // Longest program pulse, us
   localparam int ERASE_US = 20;               // Longest erase step per word, us
   localparam int PROG_CYC = PROG_US * CLK_KHZ / 1000;
   localparam int ERASE_CYC = ERASE_US * CLK_KHZ / 1000;
   localparam int CNT_W = 12;

   // Controller modes
   typedef enum logic [1:0] {FAC_IDLE, FAC_READ, FAC_PROGRAM, FAC_ERASE} fac_mode_t;

   // Array bus request from the system bus
   typedef struct packed {
      logic sel;             // Transfer to the array
      logic wr;              // Write
      logic sup;             // Supervisor privilege
      logic [16:0] addr;     // Byte address
   } fac_abus_t;

   // Peripheral bus request
   typedef struct packed {
      logic sel;
      logic wr;
      logic sup;
      logic [7:0] addr;
      logic [15:0] wdata;
   } fac_pbus_t;

   // Debug load request, one word at a time
   typedef struct packed {
      logic valid;
      logic [1:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
   } fac_dbg_t;

endpackage

//--- logic/fac_array.sv
/*
 Word-wide array model of the nonvolatile cells with a registered read port
 and a masked clearing write port.
 Assumes the sequencer only writes during program or erase.
*/
`timescale 1ns/1ps
module fac_array #(
   parameter int DEPTH = 32768,
   parameter int AW = 15
) (
   // Clock
   input wire logic ref_clk,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [31:0] rdata,
   // Write port
   input wire logic we,
   input wire logic erase,
   input wire logic [AW-1:0] waddr,
   input wire logic [31:0] wdata
);
   // Cell storage, erased contents read as ones; cells leave the factory erased
   logic [31:0] mem [DEPTH] = '{default: fac_pkg::ERASED_WORD};

   // Program clears bits only, erase sets every bit
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         if (erase)
            mem[waddr] <= fac_pkg::ERASED_WORD;
         else
            mem[waddr] <= mem[waddr] & wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // fac_array

//--- logic/fac_ctrl.sv
/*
 Flash array controller: serves array reads in one cycle, takes program and
 erase commands from the peripheral bus or the debug load port, times the
 high-voltage pulses and answers privilege violations with a bus error.
 Assumes all inputs are synchronous to ref_clk and that the requester erases
 a location before programming it.
*/
`timescale 1ns/1ps
module fac_ctrl #(
   parameter int DEPTH = fac_pkg::WORDS,
   parameter int PROG_CYCLES = fac_pkg::PROG_CYC,
   parameter int ERASE_CYCLES = fac_pkg::ERASE_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Array bus
   input wire fac_pkg::fac_abus_t abus,
   input wire logic [31:0] abus_wdata,
   output logic [31:0] abus_rdata,
   output logic abus_ready,
   output logic abus_err,
   // Peripheral bus
   input wire fac_pkg::fac_pbus_t pbus,
   output logic [15:0] pbus_rdata,
   output logic pbus_ready,
   output logic pbus_err,
   // Debug load port
   input wire fac_pkg::fac_dbg_t dbg,
   output logic dbg_ready,
   // Status
   output fac_pkg::fac_mode_t mode,
   output logic standby
);
   // Word address width of the array
   localparam int AW = fac_pkg::ADDR_W;

   // Controller state
   fac_pkg::fac_mode_t next_mode;
   logic [AW-1:0] tgt;             // Word being programmed or erased
   logic [AW-1:0] next_tgt;
   logic [AW-1:0] last;            // Last word of the erase range
   logic [AW-1:0] next_last;
   logic [31:0] data;              // Program data
   logic [31:0] next_data;
   logic [AW-1:0] cmd_addr;        // Address register
   logic [AW-1:0] next_cmd_addr;
   logic pulse;                    // Pulse running on tgt
   logic next_pulse;
   logic err;                      // Sticky status error
   logic next_err;
   // Bus answer registers
   logic [15:0] next_pbus_rdata;
   logic next_abus_err;
   logic next_pbus_err;
   logic next_pbus_ready;
   logic next_abus_ready;

   // Timer and array hookups
   logic t_load;
   logic [fac_pkg::CNT_W-1:0] t_count;
   logic t_done;
   logic arr_we;
   logic arr_erase;
   logic [31:0] arr_rdata;
   logic busy;
   logic start;
   logic [1:0] start_cmd;
   logic [AW-1:0] start_addr;
   logic [31:0] start_data;
   logic reg_ok;
   logic abus_ok_rd;
   logic abus_bad;

   // Busy when a program or erase holds the array
   function automatic logic fac_fac_busy_mode(input fac_pkg::fac_mode_t m);
      fac_fac_busy_mode = (m == fac_pkg::FAC_PROGRAM) || (m == fac_pkg::FAC_ERASE);
   endfunction

   // Reads, register writes and new commands all wait on this
   assign busy = fac_fac_busy_mode(mode);

   // Privilege checks on each bus
   assign reg_ok = pbus.sel && pbus.sup;
   assign abus_bad = abus.sel && abus.wr && !abus.sup;
   assign abus_ok_rd = abus.sel && !abus.wr && !busy;

   // Command launch: peripheral command write or debug load word
   always_comb
   begin
      // No launch unless a request below qualifies
      start = 1'b0;
      start_cmd = fac_pkg::CMD_PROG;
      start_addr = cmd_addr;
      start_data = data;
      // Debug load word takes precedence over a register command
      if (!busy && dbg.valid && dbg.cmd != 2'h0)
      begin
         start = 1'b1;
         start_cmd = dbg.cmd;
         start_addr = dbg.addr;
         start_data = dbg.data;
      end
      // Supervisor write of a nonzero code to the command register
      else if (!busy && reg_ok && pbus.wr && pbus.addr == fac_pkg::REG_CMD
               && pbus.wdata[1:0] != 2'h0)
      begin
         start = 1'b1;
         start_cmd = pbus.wdata[1:0];
      end
   end
   // Loader may hand over a word whenever the array is free
   assign dbg_ready = !busy;

   // Next values of the sequencer and registers
   always_comb
   begin
      next_mode = mode;
      next_tgt = tgt;
      next_last = last;
      next_data = data;
      next_cmd_addr = cmd_addr;
      next_pulse = 1'b0;
      next_err = err;
      // Timer runs down without reload unless a pulse starts or steps
      t_load = 1'b0;
      t_count = fac_pkg::CNT_W'(PROG_CYCLES);
      // Register writes, status included, ignored while busy or on a command launch
      if (reg_ok && pbus.wr && !busy && !start)
      begin
         // Only the addressed register takes the write
         if (pbus.addr == fac_pkg::REG_ADDR)
            next_cmd_addr = pbus.wdata[AW-1:0];
         else if (pbus.addr == fac_pkg::REG_DATA_LO)
            next_data[15:0] = pbus.wdata;
         else if (pbus.addr == fac_pkg::REG_DATA_HI)
            next_data[31:16] = pbus.wdata;
         else if (pbus.addr == fac_pkg::REG_STATUS && pbus.wdata[fac_pkg::ST_ERR])
            next_err = 1'b0;
      end
      // Error capture wins over its clear
      if (abus_bad || (pbus.sel && !pbus.sup))
         next_err = 1'b1;
      // Mode sequencing: read tracking, command launch, pulse stepping
      unique case (mode)
         fac_pkg::FAC_IDLE, fac_pkg::FAC_READ:
         begin
            next_mode = abus_ok_rd ? fac_pkg::FAC_READ : fac_pkg::FAC_IDLE;
            // Latch the word and load the first pulse
            if (start)
            begin
               next_data = start_data;
               t_load = 1'b1;
               next_pulse = 1'b1;
               // Program touches the one addressed word
               if (start_cmd == fac_pkg::CMD_PROG)
               begin
                  next_mode = fac_pkg::FAC_PROGRAM;
                  next_tgt = start_addr;
                  next_last = start_addr;
               end
               else
               begin
                  next_mode = fac_pkg::FAC_ERASE;
                  t_count = fac_pkg::CNT_W'(ERASE_CYCLES);
                  // Page erase walks the 256 words of one page
                  if (start_cmd == fac_pkg::CMD_PAGE)
                  begin
                     next_tgt = {start_addr[AW-1:fac_pkg::PAGE_W], {fac_pkg::PAGE_W{1'b0}}};
                     next_last = {start_addr[AW-1:fac_pkg::PAGE_W], {fac_pkg::PAGE_W{1'b1}}};
                  end
                  else
                  begin
                     // Mass erase walks every word, the option word at the top too
                     next_tgt = '0;
                     next_last = AW'(DEPTH - 1);
                  end
               end
            end
         end
         fac_pkg::FAC_PROGRAM, fac_pkg::FAC_ERASE:
         begin
            // Reads and commands wait until the last word is done
            next_pulse = 1'b1;
            // Pulse ends on timer expiry, never later
            if (t_done)
            begin
               next_pulse = 1'b0;
               // Last word done: back to idle
               if (tgt == last)
                  next_mode = fac_pkg::FAC_IDLE;
               else
               begin
                  // Fresh pulse for the next word of the range
                  next_tgt = tgt + 1'b1;
                  t_load = 1'b1;
                  t_count = fac_pkg::CNT_W'(ERASE_CYCLES);
                  next_pulse = 1'b1;
               end
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // Idle, with an all-ones data word that would clear nothing
         mode <= fac_pkg::FAC_IDLE;
         tgt <= '0;
         last <= '0;
         data <= fac_pkg::ERASED_WORD;
         cmd_addr <= '0;
         pulse <= 1'b0;
         err <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         tgt <= next_tgt;
         last <= next_last;
         data <= next_data;
         cmd_addr <= next_cmd_addr;
         pulse <= next_pulse;
         err <= next_err;
      end
   end

   // Pulse timer bounds every high-voltage step
   fac_timer #(.W(fac_pkg::CNT_W)) u_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(t_load),
      .count(t_count),
      .running(),
      .done(t_done)
   );

   // Cells change once, at the end of each pulse
   assign arr_we = pulse && t_done;
   assign arr_erase = (mode == fac_pkg::FAC_ERASE);

   // Storage, 32K words of 32 bits
   fac_array #(.DEPTH(DEPTH), .AW(AW)) u_array (
      .ref_clk(ref_clk),
      // Byte address bits 16:2 pick the word; the top word holds options
      .raddr(abus.addr[AW+1:2]),
      .rdata(arr_rdata),
      .we(arr_we),
      .erase(arr_erase),
      .waddr(tgt),
      .wdata(data)
   );

   // Read data are undefined while busy; zero is what shows
   assign abus_rdata = (mode == fac_pkg::FAC_READ) ? arr_rdata : '0;

   // Bus answers, registered one cycle after the request
   always_comb
   begin
      next_abus_ready = abus.sel && !abus_bad;
      next_abus_err = abus_bad;
      next_pbus_ready = reg_ok;
      next_pbus_err = pbus.sel && !pbus.sup;
      next_pbus_rdata = '0;
      // Register read data; writes and unmapped offsets read zero
      if (reg_ok && !pbus.wr)
      begin
         unique case (pbus.addr)
            fac_pkg::REG_ADDR: next_pbus_rdata = 16'(cmd_addr);
            fac_pkg::REG_DATA_LO: next_pbus_rdata = data[15:0];
            fac_pkg::REG_DATA_HI: next_pbus_rdata = data[31:16];
            fac_pkg::REG_STATUS: next_pbus_rdata = {12'h000, err, 1'(mode >> 1), 1'(mode), busy};
            default: next_pbus_rdata = '0;
         endcase
      end
   end

   // Answer registers
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // No answer pending out of reset
         abus_ready <= 1'b0;
         abus_err <= 1'b0;
         pbus_ready <= 1'b0;
         pbus_err <= 1'b0;
         pbus_rdata <= 16'h0000;
      end
      else
      begin
         abus_ready <= next_abus_ready;
         abus_err <= next_abus_err;
         pbus_ready <= next_pbus_ready;
         pbus_err <= next_pbus_err;
         pbus_rdata <= next_pbus_rdata;
      end
   end

   // Standby whenever no mode other than idle
   assign standby = (mode == fac_pkg::FAC_IDLE);
endmodule // fac_ctrl

//--- logic/fac_timer.sv
/*
 Down-counter that times one high-voltage pulse and flags its end.
 Assumes load is a one-cycle pulse.
*/
`timescale 1ns/1ps
module fac_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic load,
   input wire logic [W-1:0] count,
   // Status
   output logic running,
   output logic done
);
   logic [W-1:0] cnt;        // Remaining cycles
   logic [W-1:0] next_cnt;

   // Next count: load, then run down to zero
   always_comb
   begin
      next_cnt = cnt;
      if (load)
         next_cnt = count;
      else if (cnt != '0)
         next_cnt = cnt - 1'b1;
   end

   // Counter register
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign running = (cnt != '0);
   assign done = (cnt == {{(W-1){1'b0}}, 1'b1});
endmodule // fac_timer
